/* core/ioord_top.sv */
// Load/store ordering control between pipeline, store buffer and system bus
`timescale 1ns/1ps
module ioord_top (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         ce,
   input  wire logic                         req_valid,
   input  wire ioord_pkg::ioord_kind_t       req_kind,
   input  wire logic [ioord_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [ioord_pkg::DATA_W-1:0] req_wdata,
   input  wire logic                         cache_hit,
   input  wire logic [ioord_pkg::DATA_W-1:0] cache_rdata,
   output logic                              req_done,
   output logic [ioord_pkg::DATA_W-1:0]      req_rdata,
   output logic                              bus_req,
   output logic                              bus_we,
   output logic                              bus_io,
   output logic [ioord_pkg::ADDR_W-1:0]      bus_addr,
   output logic [ioord_pkg::DATA_W-1:0]      bus_wdata,
   input  wire logic                         bus_ack,
   input  wire logic [ioord_pkg::DATA_W-1:0] bus_rdata,
   output logic                              buffer_empty
);
   typedef enum logic [1:0] {
      S_IDLE,
      S_DRAIN,
      S_LAUNCH,
      S_WAIT
   } ioord_state_t;

   ioord_state_t                 state;
   ioord_state_t                 next_state;
   logic                         next_done;
   logic [ioord_pkg::DATA_W-1:0] next_rdata;
   logic                         next_bus_req;
   logic                         next_bus_we;
   logic                         next_bus_io;
   logic [ioord_pkg::ADDR_W-1:0] next_bus_addr;
   logic [ioord_pkg::DATA_W-1:0] next_bus_wdata;
   logic                         bus_owner;
   logic                         next_bus_owner;

   ioord_sb_if sb ();

   ioord_store_buffer u_sb (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .sb  (sb)
   );

   assign sb.push_addr = req_addr;
   assign sb.push_data = req_wdata;
   assign buffer_empty = sb.empty;

   // bus_owner high: the pipeline's own access; low: a store buffer drain
   always_comb
   begin
      next_state     = state;
      next_done      = 1'b0;
      next_rdata     = req_rdata;
      next_bus_req   = bus_req;
      next_bus_we    = bus_we;
      next_bus_io    = bus_io;
      next_bus_addr  = bus_addr;
      next_bus_wdata = bus_wdata;
      next_bus_owner = bus_owner;
      sb.push        = 1'b0;
      sb.pop         = 1'b0;
      if (bus_req && bus_ack)
      begin
         next_bus_req = 1'b0;
         sb.pop       = !bus_owner;
      end
      case (state)
         S_IDLE:
         begin
            if (req_valid && !req_done)
            begin
               case (req_kind)
                  ioord_pkg::K_LOAD_WB:
                  begin
                     if (cache_hit)
                     begin
                        next_done  = 1'b1;
                        next_rdata = cache_rdata;
                     end
                     else
                     begin
                        next_state = S_LAUNCH;
                     end
                  end
                  ioord_pkg::K_STORE_WB:
                  begin
                     if (!sb.full)
                     begin
                        sb.push   = 1'b1;
                        next_done = 1'b1;
                     end
                  end
                  default:
                  begin
                     next_state = S_DRAIN;
                  end
               endcase
            end
         end
         S_DRAIN:
         begin
            // Empty only after the final drain write was acknowledged
            if (sb.empty && !bus_req)
            begin
               if (req_kind == ioord_pkg::K_SERIALIZE)
               begin
                  next_done  = 1'b1;
                  next_state = S_IDLE;
               end
               else
               begin
                  next_state = S_LAUNCH;
               end
            end
         end
         S_LAUNCH:
         begin
            if (!bus_req)
            begin
               next_bus_req   = 1'b1;
               next_bus_owner = 1'b1;
               next_bus_we    = (req_kind == ioord_pkg::K_STORE_UC) ||
                                (req_kind == ioord_pkg::K_PORT_WR);
               next_bus_io    = (req_kind == ioord_pkg::K_PORT_RD) ||
                                (req_kind == ioord_pkg::K_PORT_WR);
               next_bus_addr  = req_addr;
               next_bus_wdata = req_wdata;
               next_state     = S_WAIT;
            end
         end
         S_WAIT:
         begin
            // Writes too finish only on the acknowledge, so the next access waits
            if (bus_ack)
            begin
               next_done  = 1'b1;
               next_rdata = bus_rdata;
               next_state = S_IDLE;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
      // Drain the head store whenever the bus is free and no own access is due
      if ((state == S_IDLE || state == S_DRAIN) && !bus_req && sb.head_valid)
      begin
         next_bus_req   = 1'b1;
         next_bus_owner = 1'b0;
         next_bus_we    = 1'b1;
         next_bus_io    = 1'b0;
         next_bus_addr  = sb.head_addr;
         next_bus_wdata = sb.head_data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state     <= S_IDLE;
         req_done  <= 1'b0;
         req_rdata <= ioord_pkg::DATA_RST;
         bus_req   <= 1'b0;
         bus_we    <= 1'b0;
         bus_io    <= 1'b0;
         bus_addr  <= ioord_pkg::ADDR_RST;
         bus_wdata <= ioord_pkg::DATA_RST;
         bus_owner <= 1'b0;
      end
      else if (ce)
      begin
         state     <= next_state;
         req_done  <= next_done;
         req_rdata <= next_rdata;
         bus_req   <= next_bus_req;
         bus_we    <= next_bus_we;
         bus_io    <= next_bus_io;
         bus_addr  <= next_bus_addr;
         bus_wdata <= next_bus_wdata;
         bus_owner <= next_bus_owner;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence own_ack_s;
      bus_req && bus_owner && bus_ack && ce;
   endsequence

   sequence drain_ack_s;
      bus_req && !bus_owner && bus_ack && ce;
   endsequence

   hit_bypass_a: assert property (ce && state == S_IDLE && req_valid && !req_done &&
      req_kind == ioord_pkg::K_LOAD_WB && cache_hit |=> req_done && req_rdata == $past(cache_rdata))
      else $error("cache hit read not completed next cycle");
   uncached_order_a: assert property ($rose(bus_req) && bus_owner &&
      (req_kind == ioord_pkg::K_LOAD_UC || req_kind == ioord_pkg::K_STORE_UC) |-> sb.empty)
      else $error("uncacheable access passed buffered stores");
   serialize_done_a: assert property (req_done && state == S_IDLE &&
      req_kind == ioord_pkg::K_SERIALIZE && $past(state) == S_DRAIN |-> sb.empty && !bus_req)
      else $error("serializing access completed with work pending");
   port_unbuffered_a: assert property (sb.push |-> req_kind == ioord_pkg::K_STORE_WB)
      else $error("non-cacheable store entered store buffer");
   port_read_wait_a: assert property ($rose(bus_req) && bus_io && !bus_we |-> sb.empty)
      else $error("port read issued with pending stores");
   port_write_done_a: assert property (own_ack_s ##0 bus_we && bus_io |=> req_done)
      else $error("port write acknowledge did not complete access");
   fifo_head_a: assert property ($rose(bus_req) && !bus_owner |->
      bus_addr == $past(sb.head_addr) && bus_we)
      else $error("drain did not take store buffer head");
   empty_on_ack_a: assert property ($rose(sb.empty) |-> $past(bus_req && !bus_owner && bus_ack))
      else $error("store buffer empty without final acknowledge");
   drain_pop_a: assert property (drain_ack_s |=> !bus_req &&
      u_sb.rd_ptr == $past(u_sb.rd_ptr) + 2'h1)
      else $error("drain acknowledge did not advance store buffer head");
endmodule : ioord_top

/* core/ioord_pkg.sv */
// Shared constants and types for the I/O access ordering block
package ioord_pkg;
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int SB_DEPTH = 4;
   localparam int SB_PTR_W = 2;
   localparam int SB_CNT_W = 3;

   localparam logic [SB_PTR_W-1:0] SB_PTR_RST  = 2'h0;
   localparam logic [SB_CNT_W-1:0] SB_CNT_RST  = 3'h0;
   localparam logic [SB_CNT_W-1:0] SB_CNT_FULL = 3'h4;
   localparam logic [ADDR_W-1:0]   ADDR_RST    = 32'h0;
   localparam logic [DATA_W-1:0]   DATA_RST    = 32'h0;

   // Access kinds presented by the pipeline
   typedef enum logic [2:0] {
      K_LOAD_WB,
      K_STORE_WB,
      K_LOAD_UC,
      K_STORE_UC,
      K_PORT_RD,
      K_PORT_WR,
      K_SERIALIZE
   } ioord_kind_t;
endpackage : ioord_pkg

/* core/ioord_sb_if.sv */
// Connection between the ordering control and its store buffer
`timescale 1ns/1ps
interface ioord_sb_if;
   logic                       push;
   logic [ioord_pkg::ADDR_W-1:0] push_addr;
   logic [ioord_pkg::DATA_W-1:0] push_data;
   logic                       full;
   logic                       empty;
   logic                       head_valid;
   logic [ioord_pkg::ADDR_W-1:0] head_addr;
   logic [ioord_pkg::DATA_W-1:0] head_data;
   logic                       pop;

   modport fifo (input push, push_addr, push_data, pop,
                 output full, empty, head_valid, head_addr, head_data);
   modport user (output push, push_addr, push_data, pop,
                 input full, empty, head_valid, head_addr, head_data);
endinterface : ioord_sb_if

/* core/ioord_store_buffer.sv */
// First-in first-out store buffer for cacheable writes
`timescale 1ns/1ps
module ioord_store_buffer (
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   ioord_sb_if.fifo   sb
);
   logic [ioord_pkg::ADDR_W-1:0]   mem_addr [ioord_pkg::SB_DEPTH];
   logic [ioord_pkg::DATA_W-1:0]   mem_data [ioord_pkg::SB_DEPTH];
   logic [ioord_pkg::SB_PTR_W-1:0] wr_ptr;
   logic [ioord_pkg::SB_PTR_W-1:0] next_wr_ptr;
   logic [ioord_pkg::SB_PTR_W-1:0] rd_ptr;
   logic [ioord_pkg::SB_PTR_W-1:0] next_rd_ptr;
   logic [ioord_pkg::SB_CNT_W-1:0] count;
   logic [ioord_pkg::SB_CNT_W-1:0] next_count;
   logic                           empty_q;
   logic                           next_empty;

   // Count drops only when the bus acknowledges the head write
   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (sb.push && !sb.full)
      begin
         next_wr_ptr = wr_ptr + 2'h1;
      end
      if (sb.pop && sb.head_valid)
      begin
         next_rd_ptr = rd_ptr + 2'h1;
      end
      next_count = count + {2'h0, sb.push && !sb.full} - {2'h0, sb.pop && sb.head_valid};
      next_empty = (next_count == ioord_pkg::SB_CNT_RST);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr  <= ioord_pkg::SB_PTR_RST;
         rd_ptr  <= ioord_pkg::SB_PTR_RST;
         count   <= ioord_pkg::SB_CNT_RST;
         empty_q <= 1'b1;
      end
      else if (ce)
      begin
         wr_ptr  <= next_wr_ptr;
         rd_ptr  <= next_rd_ptr;
         count   <= next_count;
         empty_q <= next_empty;
      end
   end

   always_ff @(posedge clk)
   begin
      if (ce && sb.push && !sb.full)
      begin
         mem_addr[wr_ptr] <= sb.push_addr;
         mem_data[wr_ptr] <= sb.push_data;
      end
   end

   assign sb.full       = (count == ioord_pkg::SB_CNT_FULL);
   assign sb.empty      = empty_q;
   assign sb.head_valid = !empty_q;
   assign sb.head_addr  = mem_addr[rd_ptr];
   assign sb.head_data  = mem_data[rd_ptr];
endmodule : ioord_store_buffer

/* testbench/ioord_bus_model.sv */
// Behavioural system bus controller that answers the ordering block
`timescale 1ns/1ps
module ioord_bus_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [3:0]  lat,
   input  wire logic        bus_req,
   input  wire logic        bus_we,
   input  wire logic        bus_io,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] bus_wdata,
   output logic             bus_ack,
   output logic [31:0]      bus_rdata
);
   logic [3:0]  wait_cnt;
   logic [31:0] log_addr [0:63];
   logic [1:0]  log_kind [0:63];
   logic [31:0] log_data [0:63];
   int          n;
   // Writes count as posted at the ack; read data is junk outside the ack cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wait_cnt  <= 4'h0;
         bus_ack   <= 1'b0;
         bus_rdata <= 32'h0;
         n         <= 0;
      end
      else
      begin
         bus_ack   <= 1'b0;
         bus_rdata <= ~bus_rdata;
         if (bus_req && !bus_ack && wait_cnt == lat)
         begin
            bus_ack     <= 1'b1;
            bus_rdata   <= bus_addr ^ 32'h5A5A_5A5A;
            log_addr[n] <= bus_addr;
            log_kind[n] <= {bus_we, bus_io};
            log_data[n] <= bus_wdata;
            n           <= n + 1;
            wait_cnt    <= 4'h0;
         end
         else if (bus_req && !bus_ack)
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : ioord_bus_model

/* testbench/io_access_ordering_bench.sv */
// Self-checking bench for the I/O access ordering block
`timescale 1ns/1ps
module io_access_ordering_bench;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   req_valid = 1'b0;
   ioord_pkg::ioord_kind_t req_kind = ioord_pkg::K_LOAD_WB;
   logic [31:0]            req_addr = 32'h0;
   logic [31:0]            req_wdata = 32'h0;
   logic                   cache_hit = 1'b0;
   logic [31:0]            cache_rdata = 32'h0;
   logic [3:0]             lat = 4'h0;
   logic                   ce = 1'b1;
   logic                   req_done, bus_req, bus_we, bus_io, bus_ack, buffer_empty;
   logic [31:0]            req_rdata, bus_addr, bus_wdata, bus_rdata, rd;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   int                     cycles = 0;
   int                     cyc;
   int                     base;

   always #2.5 clk = ~clk;

   ioord_top uut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid),
      .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
      .cache_hit(cache_hit), .cache_rdata(cache_rdata), .req_done(req_done),
      .req_rdata(req_rdata), .bus_req(bus_req), .bus_we(bus_we), .bus_io(bus_io),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
      .buffer_empty(buffer_empty));

   ioord_bus_model bm (.clk(clk), .rst(rst), .lat(lat), .bus_req(bus_req),
      .bus_we(bus_we), .bus_io(bus_io), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_ack(bus_ack), .bus_rdata(bus_rdata));

   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : chk

   task automatic req(input ioord_pkg::ioord_kind_t k, input logic [31:0] a, input logic h);
      cyc = 0;
      @(posedge clk);
      req_valid   <= 1'b1;
      req_kind    <= k;
      req_addr    <= a;
      req_wdata   <= a + 32'h1;
      cache_hit   <= h;
      cache_rdata <= ~a;
      do
      begin
         @(posedge clk);
         #1;
         cyc++;
      end
      while (req_done !== 1'b1 && cyc < 300);
      chk("req done", 32'h1, {31'h0, req_done});
      rd = req_rdata;
      // Request is ignored while done is high, so it is dropped on the next edge
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask : req

   task automatic log_is(input int i, input logic [31:0] a, input logic [1:0] k);
      chk("bus addr", a, bm.log_addr[base+i]);
      chk("bus kind", {30'h0, k}, {30'h0, bm.log_kind[base+i]});
   endtask : log_is

   // Stops at the first cycle the buffer reads empty
   task automatic drain(input int cnt);
      int k;
      k = 0;
      while (buffer_empty !== 1'b1 && k < 300)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("drain empty", 32'h1, {31'h0, buffer_empty});
      chk("acks at empty", cnt, bm.n - base);
      for (int i = 0; i < cnt; i++)
      begin
         log_is(i, 32'h100 + i * 4, 2'h2);
         chk("bus data", 32'h101 + i * 4, bm.log_data[base+i]);
      end
   endtask : drain

   task automatic t_bypass;
      lat  = 4'h6;
      base = bm.n;
      for (int i = 0; i < 3; i++)
         req(ioord_pkg::K_STORE_WB, 32'h100 + i * 4, 1'b0);
      req(ioord_pkg::K_LOAD_WB, 32'h200, 1'b1);
      chk("hit cycles", 32'h1, cyc);
      chk("hit data", ~32'h200, rd);
      chk("stores pending", 32'h0, {31'h0, buffer_empty});
      drain(3);
   endtask : t_bypass

   task automatic t_full;
      lat  = 4'hF;
      base = bm.n;
      for (int i = 0; i < 6; i++)
         req(ioord_pkg::K_STORE_WB, 32'h100 + i * 4, 1'b0);
      chk("full stall", 32'h1, {31'h0, cyc > 1});
      drain(6);
   endtask : t_full

   task automatic t_uncached;
      lat  = 4'h3;
      base = bm.n;
      req(ioord_pkg::K_STORE_WB, 32'h100, 1'b0);
      req(ioord_pkg::K_STORE_WB, 32'h104, 1'b0);
      req(ioord_pkg::K_STORE_UC, 32'h500, 1'b0);
      chk("empty at uc done", 32'h1, {31'h0, buffer_empty});
      req(ioord_pkg::K_LOAD_UC, 32'h504, 1'b0);
      chk("uc data", 32'h504 ^ 32'h5A5A_5A5A, rd);
      req(ioord_pkg::K_LOAD_WB, 32'h600, 1'b0);
      chk("miss data", 32'h600 ^ 32'h5A5A_5A5A, rd);
      log_is(0, 32'h100, 2'h2);
      log_is(1, 32'h104, 2'h2);
      log_is(2, 32'h500, 2'h2);
      log_is(3, 32'h504, 2'h0);
      log_is(4, 32'h600, 2'h0);
      chk("uc wdata", 32'h501, bm.log_data[base+2]);
   endtask : t_uncached

   task automatic t_port;
      lat  = 4'h5;
      base = bm.n;
      req(ioord_pkg::K_STORE_WB, 32'h700, 1'b0);
      req(ioord_pkg::K_PORT_RD, 32'h10, 1'b0);
      chk("port data", 32'h10 ^ 32'h5A5A_5A5A, rd);
      req(ioord_pkg::K_STORE_WB, 32'h704, 1'b0);
      req(ioord_pkg::K_PORT_WR, 32'h14, 1'b0);
      chk("port write acked", 32'h4, bm.n - base);
      chk("bus idle", 32'h0, {31'h0, bus_req});
      chk("port write unbuffered", 32'h1, {31'h0, buffer_empty});
      log_is(0, 32'h700, 2'h2);
      log_is(1, 32'h10, 2'h1);
      log_is(2, 32'h704, 2'h2);
      log_is(3, 32'h14, 2'h3);
      chk("port wdata", 32'h15, bm.log_data[base+3]);
   endtask : t_port

   task automatic t_serial;
      lat  = 4'h8;
      base = bm.n;
      req(ioord_pkg::K_STORE_WB, 32'h800, 1'b0);
      req(ioord_pkg::K_STORE_WB, 32'h804, 1'b0);
      req(ioord_pkg::K_SERIALIZE, 32'h0, 1'b0);
      chk("drained at serialize", 32'h2, bm.n - base);
      chk("empty at serialize", 32'h1, {31'h0, buffer_empty});
      chk("bus idle", 32'h0, {31'h0, bus_req});
   endtask : t_serial

   // Reset in mid-drain must discard the buffered stores
   task automatic t_reset;
      lat  = 4'hF;
      base = bm.n;
      req(ioord_pkg::K_STORE_WB, 32'h900, 1'b0);
      req(ioord_pkg::K_STORE_WB, 32'h904, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("empty after reset", 32'h1, {31'h0, buffer_empty});
      chk("bus_req after reset", 32'h0, {31'h0, bus_req});
      chk("done after reset", 32'h0, {31'h0, req_done});
      base = bm.n;
      req(ioord_pkg::K_SERIALIZE, 32'h0, 1'b0);
      chk("no stale drain", 32'h0, bm.n - base);
   endtask : t_reset

   // Clock enable low holds a hit read until it is raised again
   task automatic t_freeze;
      @(posedge clk);
      ce          <= 1'b0;
      req_valid   <= 1'b1;
      req_kind    <= ioord_pkg::K_LOAD_WB;
      req_addr    <= 32'hA00;
      cache_hit   <= 1'b1;
      cache_rdata <= 32'h1234_5678;
      repeat (3) @(posedge clk);
      #1;
      chk("frozen done", 32'h0, {31'h0, req_done});
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      #1;
      chk("thawed done", 32'h1, {31'h0, req_done});
      chk("thawed data", 32'h1234_5678, req_rdata);
      @(posedge clk);
      req_valid <= 1'b0;
      cache_hit <= 1'b0;
      #1;
   endtask : t_freeze

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         $display("BAD run length expected below 20000 seen %0d", cycles);
         fail_count++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("reset empty", 32'h1, {31'h0, buffer_empty});
      chk("reset bus_req", 32'h0, {31'h0, bus_req});
      chk("reset rdata", 32'h0, req_rdata);
      t_bypass();
      t_full();
      t_uncached();
      t_port();
      t_serial();
      t_reset();
      t_freeze();
      wrap_up();
   end
endmodule : io_access_ordering_bench
